/* File: logic/rcl_density_det.sv */
// Transition-density detector: flags a run of identical received bits.
`default_nettype none
module rcl_density_det (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Recovered bit stream
  input wire logic bit_valid,
  input wire logic bit_in,
  // Result
  output logic density_ok
);

  logic [5:0] run_q;
  logic [5:0] run_d;
  logic prev_q;
  logic prev_d;
  logic ok_q;
  logic ok_d;

  localparam logic [5:0] LIMIT = 6'(rcl_pkg::DENS_LIMIT_BITS);

  // ****************************************************************
  // Run-length count
  // ****************************************************************
  always_comb begin
    run_d = run_q;
    prev_d = prev_q;
    ok_d = ok_q;
    if (bit_valid) begin
      prev_d = bit_in;
      if (bit_in != prev_q) begin
        run_d = 6'h01;
      end else if (run_q != LIMIT) begin
        run_d = run_q + 6'h01;
      end
      // Sixty equal bits in a row hold no transition at all.
      ok_d = (run_d != LIMIT);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      run_q <= 6'h01;
      prev_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      run_q <= run_d;
      prev_q <= prev_d;
      ok_q <= ok_d;
    end
  end

  assign density_ok = ok_q;

endmodule
`default_nettype wire

/* File: logic/rcl_lock_ctrl.sv */
// One receive channel's clock-recovery lock selector and clock generator.
//
// Behaviour
// - Training reference clock paces the loop while not locked to data.
// - While tracking data, bit timing comes from received data only.
// - True and complement interface clock run continuously at 1/10 or 1/20.
// - Reclocker clock follows the recovered character clock, own phase.
// - Reclocker clock equals interface rate at select 0, twice it at 1.
// - Low reset sets all state, counters and control register to defaults.
// - With check enable high, level, range and density checks decide.
// - Any check failing locks to training; return only when all pass.
// - Sixty consecutive bits without a transition mean low density.
// - Two-bit trip select picks the signal-level threshold.
// - With check enable low, only the range check decides.
// - Force-local-clock low locks the loop to the training clock.
// - Force-local-clock low holds the link fault output low.
// - Link fault goes low on any of six fault conditions.
// - Force-local-clock high allows normal recovery on the data stream.
// - Characters change on rising edges, or on both edges at half rate.
`default_nettype none
module rcl_lock_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq,
  // Detector and reference inputs
  input wire logic training_ref_clock,
  input wire logic rate_in_range,
  input wire logic [7:0] signal_amplitude,
  // Recovered data stream
  input wire logic data_bit_valid,
  input wire logic data_bit,
  input wire logic [9:0] rx_char_in,
  // Receive outputs
  output logic track_training,
  output logic link_fault_n,
  output logic rx_interface_clock,
  output logic rx_interface_clock_n,
  output logic reclock_clock_out,
  output logic [9:0] rx_parallel_char
);

  // ****************************************************************
  // Control register and register port
  // ****************************************************************
  logic [5:0] ctrl_q;
  logic [5:0] ctrl_d;
  logic [2:0] irq_sts_q;
  logic [2:0] irq_sts_d;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_mask_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic [2:0] irq_event;
  logic [5:0] status_word;

  logic level_density_check_en;
  logic force_local_clock_n;
  logic rx_clock_rate_sel;
  logic [1:0] amplitude_trip_sel;
  logic chan_en;

  assign level_density_check_en = ctrl_q[rcl_pkg::CTRL_LDT_EN_BIT];
  assign force_local_clock_n = ctrl_q[rcl_pkg::CTRL_FORCE_N_BIT];
  assign rx_clock_rate_sel = ctrl_q[rcl_pkg::CTRL_RATE_BIT];
  assign amplitude_trip_sel =
    ctrl_q[rcl_pkg::CTRL_TRIP_LSB +: 2];
  assign chan_en = ctrl_q[rcl_pkg::CTRL_CHAN_EN_BIT];

  // ****************************************************************
  // Detectors
  // ****************************************************************
  logic trg_prev_q;
  logic trg_prev_d;
  logic [7:0] trg_idle_q;
  logic [7:0] trg_idle_d;
  logic trg_present_q;
  logic trg_present_d;
  logic trg_rise;
  logic amp_ok;
  logic density_ok;

  localparam logic [7:0] TRG_MISS = 8'(rcl_pkg::TRG_MISS_CYC);

  assign trg_rise = training_ref_clock && !trg_prev_q;
  // Threshold per channel from its own trip select.
  assign amp_ok =
    signal_amplitude >= rcl_pkg::rcl_trip_level(amplitude_trip_sel);

  always_comb begin
    trg_prev_d = training_ref_clock;
    trg_idle_d = trg_idle_q;
    trg_present_d = trg_present_q;
    if (trg_rise) begin
      trg_idle_d = 8'h00;
      trg_present_d = 1'b1;
    end else if (trg_idle_q != TRG_MISS) begin
      trg_idle_d = trg_idle_q + 8'h01;
    end else begin
      trg_present_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      trg_prev_q <= 1'b0;
      trg_idle_q <= 8'h00;
      trg_present_q <= 1'b0;
    end else begin
      trg_prev_q <= trg_prev_d;
      trg_idle_q <= trg_idle_d;
      trg_present_q <= trg_present_d;
    end
  end

  // Density is judged on received data bits only.
  rcl_density_det u_density (
    .clock(clock),
    .rstn(rstn),
    .bit_valid(data_bit_valid),
    .bit_in(data_bit),
    .density_ok(density_ok)
  );

  // ****************************************************************
  // Lock-source state machine
  // ****************************************************************
  rcl_pkg::rcl_state_t state_q;
  rcl_pkg::rcl_state_t state_d;
  logic [7:0] settle_q;
  logic [7:0] settle_d;
  logic checks_ok;
  logic track_q;
  logic track_d;
  logic fault_n_q;
  logic fault_n_d;

  localparam logic [7:0] ACQ_SETTLE = 8'(rcl_pkg::ACQ_SETTLE_CYC);

  always_comb begin
    if (level_density_check_en) begin
      checks_ok = rate_in_range && amp_ok && density_ok;
    end else begin
      checks_ok = rate_in_range;
    end
    // Forcing the local clock overrides every check.
    checks_ok = checks_ok && force_local_clock_n;
  end

  always_comb begin
    state_d = state_q;
    settle_d = settle_q;
    case (state_q)
      rcl_pkg::RCL_ST_TRAIN: begin
        settle_d = 8'h00;
        if (checks_ok) begin
          state_d = rcl_pkg::RCL_ST_ACQ;
        end
      end
      rcl_pkg::RCL_ST_ACQ: begin
        // All checks must stay good for the settle time.
        if (!checks_ok) begin
          state_d = rcl_pkg::RCL_ST_TRAIN;
        end else if (settle_q == ACQ_SETTLE) begin
          state_d = rcl_pkg::RCL_ST_DATA;
        end else begin
          settle_d = settle_q + 8'h01;
        end
      end
      rcl_pkg::RCL_ST_DATA: begin
        if (!checks_ok) begin
          state_d = rcl_pkg::RCL_ST_TRAIN;
        end
      end
      default: begin
        state_d = rcl_pkg::RCL_ST_TRAIN;
      end
    endcase
    track_d = (state_d != rcl_pkg::RCL_ST_DATA);
    fault_n_d = !(!rate_in_range || !amp_ok || !density_ok || !chan_en ||
                  !force_local_clock_n || !trg_present_q);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= rcl_pkg::RCL_ST_TRAIN;
      settle_q <= 8'h00;
      track_q <= 1'b1;
      fault_n_q <= 1'b0;
    end else begin
      state_q <= state_d;
      settle_q <= settle_d;
      track_q <= track_d;
      fault_n_q <= fault_n_d;
    end
  end

  // ****************************************************************
  // Character clocks and output characters
  // ****************************************************************
  logic [3:0] bitcnt_q;
  logic [3:0] bitcnt_d;
  logic half_phase_q;
  logic half_phase_d;
  logic ifc_q;
  logic ifc_d;
  logic ifc_n_q;
  logic ifc_n_d;
  logic rclk_q;
  logic rclk_d;
  logic [9:0] char_q;
  logic [9:0] char_d;
  logic bit_tick;

  // Tracking data, bit time comes only from the data stream.
  assign bit_tick = track_q ? trg_rise : data_bit_valid;

  always_comb begin
    bitcnt_d = bitcnt_q;
    half_phase_d = half_phase_q;
    char_d = char_q;
    if (bit_tick) begin
      if (bitcnt_q == rcl_pkg::BIT_LAST) begin
        bitcnt_d = 4'h0;
        half_phase_d = !half_phase_q;
        // A character boundary is a rising edge in character mode and
        // alternately rising and falling in half-character mode.
        char_d = rx_char_in;
      end else begin
        bitcnt_d = bitcnt_q + 4'h1;
      end
    end
    // Period of ten bits, or twenty in half-character mode.
    if (rx_clock_rate_sel) begin
      ifc_d = !half_phase_d;
    end else begin
      ifc_d = bitcnt_d < rcl_pkg::IFC_HIGH_BITS;
    end
    ifc_n_d = !ifc_d;
    // Always a ten-bit period, offset from the interface clock.
    rclk_d = (bitcnt_d >= rcl_pkg::RCLK_HIGH_FIRST) &&
             (bitcnt_d <= rcl_pkg::RCLK_HIGH_LAST);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bitcnt_q <= 4'h0;
      half_phase_q <= 1'b0;
      ifc_q <= 1'b1;
      ifc_n_q <= 1'b0;
      rclk_q <= 1'b0;
      char_q <= 10'h000;
    end else begin
      bitcnt_q <= bitcnt_d;
      half_phase_q <= half_phase_d;
      ifc_q <= ifc_d;
      ifc_n_q <= ifc_n_d;
      rclk_q <= rclk_d;
      char_q <= char_d;
    end
  end

  // ****************************************************************
  // Register access and interrupt
  // ****************************************************************
  assign status_word = {fault_n_q, track_q, trg_present_q, density_ok,
                        amp_ok, rate_in_range};
  // Entering fault, leaving data lock and reaching data lock are events.
  assign irq_event = {(state_q != rcl_pkg::RCL_ST_DATA) &&
                        (state_d == rcl_pkg::RCL_ST_DATA),
                      !track_q && track_d,
                      fault_n_q && !fault_n_d};

  always_comb begin
    ctrl_d = ctrl_q;
    irq_mask_d = irq_mask_q;
    irq_sts_d = irq_sts_q;
    rdata_d = 32'h0000_0000;
    if (reg_write) begin
      case (reg_addr)
        rcl_pkg::ADDR_CTRL: ctrl_d = reg_wdata[5:0];
        rcl_pkg::ADDR_IRQ_STS: irq_sts_d = irq_sts_q & ~reg_wdata[2:0];
        rcl_pkg::ADDR_IRQ_MASK: irq_mask_d = reg_wdata[2:0];
        default: ctrl_d = ctrl_q;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    irq_sts_d = irq_sts_d | irq_event;
    if (reg_read) begin
      case (reg_addr)
        rcl_pkg::ADDR_CTRL: rdata_d = {26'h0, ctrl_q};
        rcl_pkg::ADDR_STATUS: rdata_d = {26'h0, status_word};
        rcl_pkg::ADDR_IRQ_STS: rdata_d = {29'h0, irq_sts_q};
        rcl_pkg::ADDR_IRQ_MASK: rdata_d = {29'h0, irq_mask_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    irq_d = |(irq_sts_d & irq_mask_d);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= rcl_pkg::CTRL_RESET;
      irq_sts_q <= rcl_pkg::IRQ_STS_RESET;
      irq_mask_q <= rcl_pkg::IRQ_MASK_RESET;
      rdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irq_sts_q <= irq_sts_d;
      irq_mask_q <= irq_mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = irq_q;
  assign track_training = track_q;
  assign link_fault_n = fault_n_q;
  assign rx_interface_clock = ifc_q;
  assign rx_interface_clock_n = ifc_n_q;
  assign reclock_clock_out = rclk_q;
  assign rx_parallel_char = char_q;

endmodule
`default_nettype wire

/* File: logic/rcl_pkg.sv */
// Shared constants and types for the receive clock-recovery lock selector.
`default_nettype none
package rcl_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTRL_W = 6;
  localparam int CTRL_LDT_EN_BIT = 0;
  localparam int CTRL_FORCE_N_BIT = 1;
  localparam int CTRL_RATE_BIT = 2;
  localparam int CTRL_TRIP_LSB = 3;
  localparam int CTRL_CHAN_EN_BIT = 5;
  // Check enable, force-local inactive and channel enable start high.
  localparam logic [5:0] CTRL_RESET = 6'h23;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int STATUS_W = 6;
  localparam int ST_RATE_OK_BIT = 0;
  localparam int ST_AMP_OK_BIT = 1;
  localparam int ST_DENS_OK_BIT = 2;
  localparam int ST_TRG_OK_BIT = 3;
  localparam int ST_TRACK_TRG_BIT = 4;
  localparam int ST_FAULT_N_BIT = 5;

  // ****************************************************************
  // Interrupt status and mask fields
  // ****************************************************************
  localparam int IRQ_W = 3;
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_TO_TRAIN_BIT = 1;
  localparam int IRQ_TO_DATA_BIT = 2;
  localparam logic [2:0] IRQ_STS_RESET = 3'h0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TRG_MISS_NS = 100;
  localparam int TRG_MISS_CYC = (TRG_MISS_NS * 1000 + CLK_PERIOD_PS - 1)
                                / CLK_PERIOD_PS;
  localparam int ACQ_SETTLE_NS = 64;
  localparam int ACQ_SETTLE_CYC = (ACQ_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
                                  / CLK_PERIOD_PS;
  localparam int TMR_W = 8;
  localparam int DENS_LIMIT_BITS = 60;
  localparam int DENS_W = 6;

  // ****************************************************************
  // Character framing and clock shaping, in bit times
  // ****************************************************************
  localparam int CHAR_BITS = 10;
  localparam int BITCNT_W = 4;
  localparam logic [3:0] BIT_LAST = 4'h9;
  localparam logic [3:0] IFC_HIGH_BITS = 4'h5;
  localparam logic [3:0] RCLK_HIGH_FIRST = 4'h2;
  localparam logic [3:0] RCLK_HIGH_LAST = 4'h6;

  // ****************************************************************
  // Signal-level trip thresholds
  // ****************************************************************
  localparam logic [7:0] TRIP_LVL0 = 8'h10;
  localparam logic [7:0] TRIP_LVL1 = 8'h20;
  localparam logic [7:0] TRIP_LVL2 = 8'h40;
  localparam logic [7:0] TRIP_LVL3 = 8'h80;

  typedef enum logic [1:0] {
    RCL_ST_TRAIN = 2'b00,
    RCL_ST_ACQ = 2'b01,
    RCL_ST_DATA = 2'b11
  } rcl_state_t;

  function automatic logic [7:0] rcl_trip_level(input logic [1:0] sel);
    logic [7:0] lvl;
    case (sel)
      2'h0: lvl = TRIP_LVL0;
      2'h1: lvl = TRIP_LVL1;
      2'h2: lvl = TRIP_LVL2;
      default: lvl = TRIP_LVL3;
    endcase
    return lvl;
  endfunction

endpackage
`default_nettype wire

/* File: tb/rcl_host_model.sv */
// Host that captures receive characters on the interface clock.
`default_nettype none
module rcl_host_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Receive interface
  input wire logic rx_interface_clock,
  input wire logic [9:0] rx_parallel_char,
  // Last character taken
  output logic [9:0] cap_char
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_q;

  // Edges are seen in the system clock domain, so a character is taken
  // one cycle after the interface clock rises, when it has settled.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 1'b1;
      cap_char <= 10'h0;
    end else begin
      prev_q <= rx_interface_clock;
      if (rx_interface_clock && !prev_q) begin
        cap_char <= rx_parallel_char;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/rcl_lock_ctrl_chk.sv */
// Port-level assertions for the receive lock selector.
`default_nettype none
module rcl_lock_ctrl_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic irq,
  // Link side
  input wire logic rate_in_range,
  input wire logic track_training,
  input wire logic link_fault_n,
  input wire logic rx_interface_clock,
  input wire logic rx_interface_clock_n,
  input wire logic [9:0] rx_parallel_char
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Shadow of written control and mask bits, and range-good run count
  // ****************************************************************
  logic frc_n_q, frc_n_d, msk_z_q, msk_z_d;
  logic [7:0] run_q, run_d;

  always_comb begin
    frc_n_d = frc_n_q;
    msk_z_d = msk_z_q;
    run_d = 8'h0;
    if (rate_in_range) begin
      run_d = (run_q == 8'hff) ? run_q : run_q + 8'h1;
    end
    if (reg_write && reg_addr == rcl_pkg::ADDR_CTRL) begin
      frc_n_d = reg_wdata[rcl_pkg::CTRL_FORCE_N_BIT];
    end
    if (reg_write && reg_addr == rcl_pkg::ADDR_IRQ_MASK) begin
      msk_z_d = (reg_wdata[2:0] == 3'h0);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      frc_n_q <= 1'b1;
      msk_z_q <= 1'b1;
      run_q <= 8'h0;
    end else begin
      frc_n_q <= frc_n_d;
      msk_z_q <= msk_z_d;
      run_q <= run_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_rdata_idle: assert property (
    !$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_rd_unmapped: assert property (
    reg_read && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
    else $error("unmapped read returned data");
  a_force_train: assert property (
    !frc_n_q |-> ##[1:2] track_training)
    else $error("forced local clock not tracking training");
  a_force_fault: assert property (
    !frc_n_q |-> ##[1:2] !link_fault_n)
    else $error("forced local clock without fault");
  a_rate_drop: assert property (
    !rate_in_range |-> ##[1:2] (track_training && !link_fault_n))
    else $error("range failure did not force training");
  a_acq_settle: assert property (
    $fell(track_training) |-> run_q >= 8'h11)
    else $error("data lock taken before settle time");
  a_char_ifc: assert property (
    !$stable(rx_parallel_char) |-> !$stable(rx_interface_clock))
    else $error("character changed off a clock edge");
  a_clk_compl: assert property (
    rx_interface_clock != rx_interface_clock_n)
    else $error("interface clocks not complementary");
  a_irq_masked: assert property (
    msk_z_q |-> !irq)
    else $error("interrupt raised with all sources masked");

  c_lock: cover property ($fell(track_training));
  c_irq: cover property ($rose(irq));
  c_unmapped: cover property (reg_read && reg_addr[1:0] != 2'h0);
endmodule

bind rcl_lock_ctrl rcl_lock_ctrl_chk u_chk (
  .clock(clock),
  .rstn(rstn),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .reg_rdata(reg_rdata),
  .irq(irq),
  .rate_in_range(rate_in_range),
  .track_training(track_training),
  .link_fault_n(link_fault_n),
  .rx_interface_clock(rx_interface_clock),
  .rx_interface_clock_n(rx_interface_clock_n),
  .rx_parallel_char(rx_parallel_char)
);
`default_nettype wire

/* File: tb/rcl_lock_ctrl_tb.sv */
// Self-checking testbench for the receive lock selector.
`default_nettype none
module rcl_lock_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rstn, reg_write, reg_read, irq, training_ref_clock;
  logic rate_in_range, data_bit_valid, data_bit, track_training;
  logic link_fault_n, rx_interface_clock, rx_interface_clock_n;
  logic reclock_clock_out, rd_p, trg_on, hold, slow, chr_hold;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0] signal_amplitude;
  logic [9:0] rx_char_in, rx_parallel_char, cap_char, cv;
  logic [31:0] expq[$];
  int miscompares, checks, cyc;

  rcl_lock_ctrl dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq(irq),
    .training_ref_clock(training_ref_clock),
    .rate_in_range(rate_in_range), .signal_amplitude(signal_amplitude),
    .data_bit_valid(data_bit_valid), .data_bit(data_bit),
    .rx_char_in(rx_char_in), .track_training(track_training),
    .link_fault_n(link_fault_n), .rx_interface_clock(rx_interface_clock),
    .rx_interface_clock_n(rx_interface_clock_n),
    .reclock_clock_out(reclock_clock_out),
    .rx_parallel_char(rx_parallel_char));
  rcl_host_model host (.clock(clock), .rstn(rstn),
    .rx_interface_clock(rx_interface_clock),
    .rx_parallel_char(rx_parallel_char), .cap_char(cap_char));

  // ****************************************************************
  // Clock, stimulus and watchdog
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    if (trg_on) training_ref_clock <= ~training_ref_clock;
    data_bit_valid <= slow ? ~data_bit_valid : 1'b1;
    data_bit <= hold ? 1'b1 : 1'($urandom);
    if (!chr_hold) rx_char_in <= 10'($urandom);
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end

  // Register answers are taken at the falling edge, clear of updates.
  always @(negedge clock) begin
    if (rd_p) chk(reg_rdata, expq.pop_front());
    rd_p = reg_read;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expq.push_back(e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
  endtask

  // Data lock needs seventeen good edges after leaving training.
  task automatic settle();
    repeat (24) @(posedge clock);
  endtask

  task automatic per(input logic rc, input int exp);
    int n, r, g;
    logic p, c;
    n = 0;
    r = 0;
    g = 0;
    p = 1'b1;
    while (r < 2 && g < 300) begin
      @(negedge clock);
      c = rc ? reclock_clock_out : rx_interface_clock;
      if (c && !p) r++;
      if (r == 1) n++;
      p = c;
      g++;
    end
    chk(32'(n), 32'(exp));
    // Hand back on a rising edge so that later stimulus keeps to it.
    @(posedge clock);
  endtask

  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    void'($urandom(11));
    {rstn, reg_write, reg_read, training_ref_clock, data_bit} = 5'h0;
    {rd_p, hold, slow, chr_hold} = 4'h0;
    {rate_in_range, data_bit_valid, trg_on} = 3'h7;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    signal_amplitude = 8'hff;
    rx_char_in = 10'h0;
    miscompares = 0;
    checks = 0;
    cyc = 0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    rd(rcl_pkg::ADDR_CTRL, 32'h23);
    rd(rcl_pkg::ADDR_IRQ_MASK, 32'h0);
    rd(4'h2, 32'h0);
    settle();
    rd(rcl_pkg::ADDR_STATUS, 32'h2f);
    $display("test lock to data done");
    for (int s = 0; s < 4; s++) begin
      wr(rcl_pkg::ADDR_CTRL, 32'h23 | (s << 3));
      signal_amplitude <= (8'h10 << s) - 8'h1;
      settle();
      rd(rcl_pkg::ADDR_STATUS, 32'h1d);
      signal_amplitude <= (8'h10 << s) + 8'h1;
      settle();
      rd(rcl_pkg::ADDR_STATUS, 32'h2f);
    end
    $display("test trip levels done");
    wr(rcl_pkg::ADDR_CTRL, 32'h22);
    signal_amplitude <= 8'h0;
    settle();
    rd(rcl_pkg::ADDR_STATUS, 32'h0d);
    signal_amplitude <= 8'hff;
    wr(rcl_pkg::ADDR_CTRL, 32'h23);
    settle();
    $display("test check enable low done");
    wr(rcl_pkg::ADDR_IRQ_STS, 32'h7);
    wr(rcl_pkg::ADDR_IRQ_MASK, 32'h1);
    wr(rcl_pkg::ADDR_CTRL, 32'h21);
    settle();
    rd(rcl_pkg::ADDR_STATUS, 32'h1f);
    chk(32'(irq), 32'h1);
    rd(rcl_pkg::ADDR_IRQ_STS, 32'h3);
    wr(rcl_pkg::ADDR_IRQ_MASK, 32'h0);
    wr(rcl_pkg::ADDR_CTRL, 32'h23);
    settle();
    chk(32'(irq), 32'h0);
    wr(rcl_pkg::ADDR_IRQ_STS, 32'h3);
    rd(rcl_pkg::ADDR_IRQ_STS, 32'h4);
    $display("test force local and interrupts done");
    rate_in_range <= 1'b0;
    settle();
    rd(rcl_pkg::ADDR_STATUS, 32'h1e);
    rate_in_range <= 1'b1;
    settle();
    hold <= 1'b1;
    repeat (30) @(posedge clock);
    rd(rcl_pkg::ADDR_STATUS, 32'h2f);
    repeat (40) @(posedge clock);
    rd(rcl_pkg::ADDR_STATUS, 32'h1b);
    hold <= 1'b0;
    settle();
    trg_on <= 1'b0;
    repeat (40) @(posedge clock);
    rd(rcl_pkg::ADDR_STATUS, 32'h07);
    trg_on <= 1'b1;
    wr(rcl_pkg::ADDR_CTRL, 32'h03);
    settle();
    rd(rcl_pkg::ADDR_STATUS, 32'h0f);
    wr(rcl_pkg::ADDR_CTRL, 32'h23);
    settle();
    $display("test fault sources done");
    per(1'b0, 10);
    per(1'b1, 10);
    chr_hold <= 1'b1;
    cv = 10'($urandom);
    @(posedge clock);
    rx_char_in <= cv;
    repeat (30) @(posedge clock);
    chk(32'(cap_char), 32'(cv));
    chr_hold <= 1'b0;
    slow <= 1'b1;
    repeat (4) @(posedge clock);
    per(1'b0, 20);
    slow <= 1'b0;
    wr(rcl_pkg::ADDR_CTRL, 32'h27);
    // Let the mode switch's own clock step pass before timing a period.
    repeat (4) @(posedge clock);
    per(1'b0, 20);
    per(1'b1, 10);
    $display("test clock rates done");
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd(rcl_pkg::ADDR_CTRL, 32'h23);
    repeat (2) @(posedge clock);
    $display("test second reset done");
    conclude();
  end
endmodule
`default_nettype wire
